// ==== gcf_pkg.sv ====
package gcf_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_OTYPE = 8'h04;
  localparam logic [7:0] OFF_SPEED = 8'h08;
  localparam logic [7:0] OFF_PULL = 8'h0c;
  localparam logic [7:0] OFF_INPUT = 8'h10;
  localparam logic [7:0] OFF_OUTPUT = 8'h14;
  localparam logic [7:0] OFF_SETCLR = 8'h18;
  localparam logic [7:0] OFF_FREEZE = 8'h1c;
  localparam logic [7:0] OFF_AF_LOW = 8'h20;
  localparam logic [7:0] OFF_AF_HIGH = 8'h24;
  localparam logic [7:0] OFF_CLEAR = 8'h28;
  // field positions and values
  localparam int KEY_BIT = 16;
  localparam logic [1:0] MODE_ALTFUNC = 2'b10;
  // reset values and response codes
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // key sequence tracker
  typedef enum logic [1:0] {
    GCF_KEY_IDLE,
    GCF_KEY_ONE,
    GCF_KEY_ZERO
  } gcf_key_e;
endpackage : gcf_pkg

// ==== gcf_field_merge.sv ====
`timescale 1ns/1ns
// per-pin guarded merge of a write into a packed field register
module gcf_field_merge #(
  parameter int FW = 2
) (
  // values
  input wire logic [31:0] old_val,
  input wire logic [31:0] wr_val,
  input wire logic [3:0] wstrb,
  // pins frozen
  input wire logic [31/FW:0] frozen,
  // merged result
  output logic [31:0] new_val
);
  // a field changes only when unfrozen and its byte lane is strobed
  always_comb begin
    new_val = old_val;
    for (int i = 0; i < 32; i++) begin
      if (!frozen[i/FW] && wstrb[i/8]) begin
        new_val[i] = wr_val[i];
      end
    end
  end
endmodule : gcf_field_merge

// ==== gcf_port.sv ====
`timescale 1ns/1ns
// Contract
// R1 - freeze bits 15:0 writable only while key bit reads zero
// R2 - freeze bit one protects that pin once the key is armed
// R3 - key arms on writes key1, key0, key1 with mask, then read; code arms on the third write, no read needed
// R4 - software keeps the same mask on all three key writes
// R5 - any wrong key, order or mask aborts the arming attempt
// R6 - after arming the freeze register is unwritable until reset
// R7 - key bit reads one after first arming until any reset
// R8 - software may read the key bit to confirm arming
// R9 - protected pin configuration unmodifiable until system reset; code drops protection on peripheral reset too
// R10 - freeze register resets to zero, bits 31:17 reserved
// R11 - low bank holds 4-bit function selectors for pins 0..7
// R12 - high bank selectors for pins 8..15, both reset to zero
// R13 - bit-clear register is write-only and reads as zero
// R14 - writing one clears matching output latch bit, zero no effect
// R15 - function selector applies only when pin mode field is 10
// R16 - output latch is 16-bit rw, also changed by set/clear regs
// R17 - frozen pins ignore mode, type, speed, pull, function writes
// R18 - key tracker restarts idle after abort or reset
module gcf_port (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic periph_rst_n,
  // axi4-lite write address
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // axi4-lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // axi4-lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read address
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // axi4-lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // pad side
  input wire logic [15:0] pin_in,
  output logic [31:0] pin_mode_field,
  output logic [15:0] pin_otype,
  output logic [31:0] pin_speed,
  output logic [31:0] pin_pull,
  output logic [15:0] output_latch,
  output logic [63:0] pin_func_active,
  output logic freeze_key
);
  logic [31:0] aw_addr_q;
  logic aw_full;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_full;
  logic [15:0] pin_freeze_bit;
  logic key_sticky;
  logic [15:0] seq_mask;
  gcf_pkg::gcf_key_e key_state;
  logic [31:0] altfunc_sel_low;
  logic [31:0] altfunc_sel_high;
  logic [15:0] in_meta;
  logic [15:0] in_sync;
  logic [31:0] next_mode;
  logic [31:0] next_speed;
  logic [31:0] next_pull;
  logic [31:0] next_af_low;
  logic [31:0] next_af_high;
  logic [31:0] pin2_frozen;
  logic do_write;
  logic [7:0] wa;
  logic wr_known;
  logic frozen_now;

  // two-bit fields map to pins by index/2, so expand each freeze bit
  function automatic logic [31:0] pair_mask(input logic [15:0] m);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[2*i] = m[i];
      r[2*i+1] = m[i];
    end
    return r;
  endfunction : pair_mask

  // address decode shared by read and write paths
  function automatic logic addr_known(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= gcf_pkg::OFF_CLEAR;
  endfunction : addr_known

  // one key step: full-word strobe, expected key value, unchanged mask
  function automatic logic key_step(input logic [31:0] d,
                                    input logic [3:0] s,
                                    input logic [15:0] m,
                                    input logic k);
    return d[gcf_pkg::KEY_BIT] == k && s == 4'hf && d[15:0] == m;
  endfunction : key_step

  // selector passes only in multiplexing mode, other modes show zero
  function automatic logic [3:0] func_gate(input logic [1:0] mode,
                                           input logic [3:0] sel);
    return mode == gcf_pkg::MODE_ALTFUNC ? sel : 4'h0; // [R15]
  endfunction : func_gate

  assign frozen_now = key_sticky;
  assign wa = aw_addr_q[7:0];
  assign do_write = aw_full && w_full && !s_bvalid;
  assign wr_known = addr_known(wa);
  assign s_awready = !aw_full;
  assign s_wready = !w_full;
  assign s_arready = !s_rvalid;
  assign freeze_key = key_sticky;

  // address and data latched independently, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr_q <= gcf_pkg::RST_ZERO;
      w_full <= 1'b0;
      w_data_q <= gcf_pkg::RST_ZERO;
      w_strb_q <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full <= 1'b1;
        aw_addr_q <= {24'h00_0000, s_awaddr};
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_full <= 1'b1;
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= gcf_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_known ? gcf_pkg::RESP_OKAY : gcf_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // key tracker; full-word writes only, else the step counts as wrong
  // peripheral reset drops the key too, so protection lapses with it
  always_ff @(posedge aclk) begin
    if (!aresetn || !periph_rst_n) begin
      key_state <= gcf_pkg::GCF_KEY_IDLE; // [R18]
      seq_mask <= 16'h0000;
      key_sticky <= 1'b0; // [R7] [R10]
    end else if (do_write && wa == gcf_pkg::OFF_FREEZE && !key_sticky) begin
      unique case (key_state)
        gcf_pkg::GCF_KEY_IDLE: begin
          if (w_data_q[gcf_pkg::KEY_BIT] && w_strb_q == 4'hf) begin
            key_state <= gcf_pkg::GCF_KEY_ONE; // [R3]
            seq_mask <= w_data_q[15:0];
          end
        end
        gcf_pkg::GCF_KEY_ONE: begin
          if (key_step(w_data_q, w_strb_q, seq_mask, 1'b0)) begin
            key_state <= gcf_pkg::GCF_KEY_ZERO; // [R3]
          end else begin
            key_state <= gcf_pkg::GCF_KEY_IDLE; // [R5] [R18]
          end
        end
        gcf_pkg::GCF_KEY_ZERO: begin
          key_state <= gcf_pkg::GCF_KEY_IDLE;
          if (key_step(w_data_q, w_strb_q, seq_mask, 1'b1)) begin
            key_sticky <= 1'b1; // [R3] [R6]
          end // else aborted [R5]
        end
        default: begin
          // unused encoding, fall back to idle
          key_state <= gcf_pkg::GCF_KEY_IDLE; // [R18]
        end
      endcase
    end
  end

  // freeze bits; only system reset clears them, peripheral reset keeps them but unfreezes via the key
  // every key write lands here too, carrying the same mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_freeze_bit <= 16'h0000; // [R10]
    end else if (do_write && wa == gcf_pkg::OFF_FREEZE && !key_sticky) begin
      // [R1] [R6]
      if (w_strb_q[0]) pin_freeze_bit[7:0] <= w_data_q[7:0];
      if (w_strb_q[1]) pin_freeze_bit[15:8] <= w_data_q[15:8];
    end
  end

  // protection only counts once the key is armed
  assign pin2_frozen = frozen_now ? pair_mask(pin_freeze_bit) : '0; // [R2]

  gcf_field_merge #(.FW(2)) u_mode (
    .old_val(pin_mode_field),
    .wr_val(w_data_q),
    .wstrb(w_strb_q),
    .frozen(frozen_now ? pin_freeze_bit : 16'h0000),
    .new_val(next_mode)
  );
  gcf_field_merge #(.FW(2)) u_speed (
    .old_val(pin_speed),
    .wr_val(w_data_q),
    .wstrb(w_strb_q),
    .frozen(frozen_now ? pin_freeze_bit : 16'h0000),
    .new_val(next_speed)
  );
  gcf_field_merge #(.FW(2)) u_pull (
    .old_val(pin_pull),
    .wr_val(w_data_q),
    .wstrb(w_strb_q),
    .frozen(frozen_now ? pin_freeze_bit : 16'h0000),
    .new_val(next_pull)
  );
  gcf_field_merge #(.FW(4)) u_af_low (
    .old_val(altfunc_sel_low),
    .wr_val(w_data_q),
    .wstrb(w_strb_q),
    .frozen(frozen_now ? pin_freeze_bit[7:0] : 8'h00),
    .new_val(next_af_low)
  );
  gcf_field_merge #(.FW(4)) u_af_high (
    .old_val(altfunc_sel_high),
    .wr_val(w_data_q),
    .wstrb(w_strb_q),
    .frozen(frozen_now ? pin_freeze_bit[15:8] : 8'h00),
    .new_val(next_af_high)
  );

  // configuration registers, writes masked per frozen pin
  // otype has one bit per pin, so it reads the even bit of each pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_mode_field <= gcf_pkg::RST_ZERO;
      pin_otype <= 16'h0000;
      pin_speed <= gcf_pkg::RST_ZERO;
      pin_pull <= gcf_pkg::RST_ZERO;
      altfunc_sel_low <= gcf_pkg::RST_ZERO; // [R12]
      altfunc_sel_high <= gcf_pkg::RST_ZERO; // [R12]
    end else if (do_write) begin
      unique case (wa)
        gcf_pkg::OFF_MODE: pin_mode_field <= next_mode; // [R17] [R9]
        gcf_pkg::OFF_OTYPE: begin
          for (int i = 0; i < 16; i++) begin
            if (!pin2_frozen[2*i] && w_strb_q[i/8]) begin
              pin_otype[i] <= w_data_q[i]; // [R17]
            end
          end
        end
        gcf_pkg::OFF_SPEED: pin_speed <= next_speed; // [R17]
        gcf_pkg::OFF_PULL: pin_pull <= next_pull; // [R17]
        gcf_pkg::OFF_AF_LOW: altfunc_sel_low <= next_af_low; // [R11]
        gcf_pkg::OFF_AF_HIGH: altfunc_sel_high <= next_af_high; // [R12]
        default: begin
        end
      endcase
    end
  end

  // output latch: direct write, set/clear and clear registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_latch <= 16'h0000;
    end else if (do_write) begin
      if (wa == gcf_pkg::OFF_OUTPUT) begin
        if (w_strb_q[0]) output_latch[7:0] <= w_data_q[7:0]; // [R16]
        if (w_strb_q[1]) output_latch[15:8] <= w_data_q[15:8];
      end else if (wa == gcf_pkg::OFF_SETCLR) begin
        // set half wins over clear half on the same pin
        output_latch <= (output_latch & ~w_data_q[31:16])
                        | w_data_q[15:0]; // [R16]
      end else if (wa == gcf_pkg::OFF_CLEAR) begin
        output_latch <= output_latch & ~w_data_q[15:0]; // [R14]
      end
    end
  end

  // selector drives the pin only in multiplexing mode
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      pin_func_active[4*p +: 4] =
        func_gate(pin_mode_field[2*p +: 2], altfunc_sel_low[4*p +: 4]);
      pin_func_active[32+4*p +: 4] =
        func_gate(pin_mode_field[16+2*p +: 2], altfunc_sel_high[4*p +: 4]);
    end
  end

  // pad inputs are asynchronous, two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta <= 16'h0000;
      in_sync <= 16'h0000;
    end else begin
      in_meta <= pin_in;
      in_sync <= in_meta;
    end
  end

  // read path, one-cycle latency
  // decode on the live address; arready stays low while an answer waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= gcf_pkg::RST_ZERO;
      s_rresp <= gcf_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp <= addr_known(s_araddr) ? gcf_pkg::RESP_OKAY
                                      : gcf_pkg::RESP_SLVERR;
      unique case (s_araddr)
        gcf_pkg::OFF_MODE: s_rdata <= pin_mode_field;
        gcf_pkg::OFF_OTYPE: s_rdata <= {16'h0000, pin_otype};
        gcf_pkg::OFF_SPEED: s_rdata <= pin_speed;
        gcf_pkg::OFF_PULL: s_rdata <= pin_pull;
        gcf_pkg::OFF_INPUT: s_rdata <= {16'h0000, in_sync};
        gcf_pkg::OFF_OUTPUT: s_rdata <= {16'h0000, output_latch};
        gcf_pkg::OFF_FREEZE: begin
          s_rdata <= {15'h0000, key_sticky, pin_freeze_bit}; // [R7] [R10]
        end
        gcf_pkg::OFF_AF_LOW: s_rdata <= altfunc_sel_low;
        gcf_pkg::OFF_AF_HIGH: s_rdata <= altfunc_sel_high;
        default: s_rdata <= gcf_pkg::RST_ZERO; // [R13] clear, set/clear
      endcase
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule : gcf_port

// ==== gcf_port_monitor.sv ====
`timescale 1ns/1ns
module gcf_port_monitor (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic periph_rst_n,
  // bus handshakes
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  // pad side
  input wire logic [31:0] pin_mode_field,
  input wire logic [63:0] pin_func_active,
  input wire logic freeze_key
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers stand until the master takes them
  chk_bresp_stands: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write response dropped early");
  chk_rdata_stands: assert property (s_rvalid && !s_rready |=>
    s_rvalid && $stable(s_rdata)) else $error("read data not held");
  chk_read_latency: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  chk_read_retire: assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("read answer not retired");
  chk_one_read: assert property (s_rvalid |-> !s_arready)
    else $error("second read taken");
  // key stays set until a peripheral reset clears it
  chk_key_sticky: assert property (
    freeze_key && periph_rst_n |=> freeze_key)
    else $error("key bit cleared without reset");
  chk_key_clear: assert property (!periph_rst_n |=> !freeze_key)
    else $error("key bit survived peripheral reset");
  // selector reaches a pin only in the multiplexing mode
  chk_func_gate_lo: assert property (pin_mode_field[1:0] != 2'b10 |->
    pin_func_active[3:0] == 4'h0) else $error("pin 0 function leaked");
  chk_func_gate_hi: assert property (
    pin_mode_field[31:30] != 2'b10 |-> pin_func_active[63:60] == 4'h0)
    else $error("pin 15 function leaked");
  cov_write: cover property (s_bvalid && s_bready);
  cov_read: cover property (s_rvalid && s_rready);
  cov_arm: cover property ($rose(freeze_key));
endmodule : gcf_port_monitor

bind gcf_port gcf_port_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .periph_rst_n(periph_rst_n),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
  .s_rvalid(s_rvalid), .s_rready(s_rready), .s_bvalid(s_bvalid),
  .s_bready(s_bready), .pin_mode_field(pin_mode_field),
  .pin_func_active(pin_func_active), .freeze_key(freeze_key)
);

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  logic aclk, aresetn, periph_rst_n, freeze_key;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd_val, pin_mode_field, pin_speed, pin_pull;
  logic [3:0] s_wstrb;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [15:0] pin_otype, output_latch;
  logic [63:0] pin_func_active;
  int failures, checks;
  // pads idle low, only register paths exercised
  gcf_port dut_u (.aclk(aclk), .aresetn(aresetn), .periph_rst_n(periph_rst_n),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .pin_in(16'h0000),
    .pin_mode_field(pin_mode_field), .pin_otype(pin_otype),
    .pin_speed(pin_speed), .pin_pull(pin_pull), .output_latch(output_latch),
    .pin_func_active(pin_func_active), .freeze_key(freeze_key));
  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic conclude;
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic cmp(input string n, input logic [31:0] g,
                     input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready === 1'b1) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    rsp = s_bresp;
  endtask : wr
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    rd_val = s_rdata;
    rsp = s_rresp;
    cmp(n, rd_val, e);
  endtask : rc
  task automatic t_reset_vals;
    rc("freeze", 8'h1c, 32'h0000_0000);
    rc("af_low", 8'h20, 32'h0000_0000);
    rc("af_high", 8'h24, 32'h0000_0000);
    rc("clear", 8'h28, 32'h0000_0000);
    rc("unmapped", 8'h2c, 32'h0000_0000);
    cmp("rresp", {30'h0, rsp}, 32'h0000_0002);
    wr(8'h2c, 32'hffff_ffff);
    cmp("bresp", {30'h0, rsp}, 32'h0000_0002);
  endtask : t_reset_vals
  // master holds the answers back; they must stand until taken
  task automatic t_stall;
    s_bready <= 1'b0;
    s_rready <= 1'b0;
    wr(8'h24, 32'h0000_0007);
    repeat (2) @(posedge aclk);
    s_bready <= 1'b1;
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    cmp("bresp", {30'h0, rsp}, 32'h0000_0000);
    rc("af_high", 8'h24, 32'h0000_0007);
    repeat (2) @(posedge aclk);
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    cmp("rdata_held", s_rdata, 32'h0000_0007);
  endtask : t_stall
  task automatic t_selectors;
    wr(8'h20, 32'h7654_3210);
    rc("af_low", 8'h20, 32'h7654_3210);
    wr(8'h24, 32'h5670_1234);
    rc("af_high", 8'h24, 32'h5670_1234);
    wr(8'h00, 32'h8000_0008);
    cmp("func_hi", pin_func_active[63:32], 32'h5000_0000);
    cmp("func_lo", pin_func_active[31:0], 32'h0000_0010);
  endtask : t_selectors
  // reserved upper bits set on purpose
  task automatic t_clear;
    wr(8'h14, 32'h0000_ffff);
    wr(8'h28, 32'hffff_00f0);
    cmp("bresp", {30'h0, rsp}, 32'h0000_0000);
    cmp("latch", {16'h0, output_latch}, 32'h0000_ff0f);
    rc("clear", 8'h28, 32'h0000_0000);
    rc("output", 8'h14, 32'h0000_ff0f);
  endtask : t_clear
  // aborted attempt with a changed mask, then a clean one
  task automatic t_key;
    wr(8'h1c, 32'h0001_0003);
    wr(8'h1c, 32'h0000_0005);
    cmp("key_abort", {31'h0, freeze_key}, 32'h0000_0000);
    wr(8'h1c, 32'h0000_0003);
    wr(8'h1c, 32'h0001_0003);
    wr(8'h1c, 32'h0000_0003);
    wr(8'h1c, 32'h0001_0003);
    cmp("key_arm", {31'h0, freeze_key}, 32'h0000_0001);
    rc("freeze", 8'h1c, 32'h0001_0003);
  endtask : t_key
  task automatic t_frozen;
    wr(8'h00, 32'hffff_ffff);
    rc("mode", 8'h00, 32'hffff_fff8);
    wr(8'h20, 32'hffff_ffff);
    rc("af_low", 8'h20, 32'hffff_ff10);
    wr(8'h04, 32'h0000_ffff);
    cmp("otype", {16'h0, pin_otype}, 32'h0000_fffc);
    wr(8'h08, 32'hffff_ffff);
    cmp("speed", pin_speed, 32'hffff_fff0);
    wr(8'h0c, 32'hffff_ffff);
    cmp("pull", pin_pull, 32'hffff_fff0);
    wr(8'h1c, 32'h0000_ffff);
    rc("freeze", 8'h1c, 32'h0001_0003);
  endtask : t_frozen
  task automatic t_resets;
    periph_rst_n <= 1'b0;
    @(posedge aclk);
    periph_rst_n <= 1'b1;
    @(posedge aclk);
    rc("freeze", 8'h1c, 32'h0000_0003);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc("freeze", 8'h1c, 32'h0000_0000);
    rc("mode", 8'h00, 32'h0000_0000);
    wr(8'h00, 32'hffff_ffff);
    rc("mode", 8'h00, 32'hffff_ffff);
    cmp("latch", {16'h0, output_latch}, 32'h0000_0000);
  endtask : t_resets
  // main sequence
  initial begin
    failures = 0;
    checks = 0;
    aresetn = 1'b0;
    periph_rst_n = 1'b1;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'hf;
    s_awvalid = 1'b0;
    s_wvalid = 1'b0;
    s_arvalid = 1'b0;
    s_bready = 1'b1;
    s_rready = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_vals();
    t_selectors();
    t_stall();
    t_clear();
    t_key();
    t_frozen();
    t_resets();
    conclude();
  end
  // watchdog, far beyond the hundred or so cycles needed
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule : tb_top
